// [hdl/pmi_mac_side_if.sv]
// mac-facing side of a 10/100 phy: mii/rmii/reverse mii, loopback, straps, resets, registers
//
// How it works
// (RULE_01) Data moves as 4-bit nibbles both speeds.
// (RULE_02) Carrier sense while receiving or transmitting.
// (RULE_03) Collision when half duplex transmit meets receive.
// (RULE_04) Mac raises enable, then nibbles in order.
// (RULE_05) Mii: device makes tx clock, samples nibble.
// (RULE_06) Rx valid rises with nibbles on rx clock.
// (RULE_07) Rmii clock-in: pin feeds pll, crystal optional.
// (RULE_08) Rmii clock-out: device drives 50mhz reference.
// (RULE_09) Reverse mii: both clocks become inputs.
// (RULE_10) Internal loopback: transmit returns into receive path.
// (RULE_11) External stub: data goes through full media.
// (RULE_12) Remote loopback bit returns tx to rx.
// (RULE_13) Straps latched when power-on reset releases.
// (RULE_14) Two-bit strap picks mii, reverse, rmii variants.
// (RULE_15) Strap picks led or wake interrupt pin.
// (RULE_16) Led straps give address bits one, zero.
// (RULE_17) Reset pin low 10ms restores all, relatches.
// (RULE_18) Control bit 15 resets registers, keeps straps.
// (RULE_19) Host waits 100us after software reset.
// (RULE_20) Self-clearing fields fire, then return default.
// (RULE_21) Soft reset clears/sets marked fields; read clears.
// (RULE_22) Strap-dependent fields reset from latched straps.
// (RULE_23) Isolate floats mac outputs, ignores mac inputs; crs and col stay driven.
// (RULE_24) Control bit 14 enables internal loopback.
// (RULE_25) Sticky high/low fields hold until read.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pmi_mac_side_if
  import pmi_pkg::*;
#(
  parameter int unsigned HRST_CYC = HARD_RST_CYC
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hard_reset_n_pin,
  input wire logic [3:0] mii_txd_i,
  input wire logic mii_tx_en_i,
  input wire logic mii_tx_clk_i,
  output logic mii_tx_clk_o,
  output logic mii_tx_clk_oe,
  input wire logic mii_rx_clk_i,
  output logic mii_rx_clk_o,
  output logic mii_rx_clk_oe,
  input wire logic [3:0] mii_rxd_i,
  output logic [3:0] mii_rxd_o,
  output logic mii_rxd_oe,
  input wire logic mii_rx_dv_i,
  output logic mii_rx_dv_o,
  output logic mii_rx_dv_oe,
  output logic mii_crs_o,
  output logic mii_col_o,
  input wire logic led0_i,
  output logic led0_o,
  output logic led0_oe,
  input wire logic led1_i,
  output logic led1_o,
  output logic led1_oe,
  output logic [3:0] line_tx_d,
  output logic line_tx_stb,
  input wire logic [3:0] line_rx_d,
  input wire logic line_rx_stb,
  input wire logic line_rx_dv,
  input wire logic link_up,
  input wire logic wol_req,
  output logic an_restart_pulse,
  output logic an_enable,
  output logic power_down,
  output logic pll_ref_from_pin,
  output logic [4:0] phy_addr
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (HRST_CYC < 1 || HRST_CYC > 4194304)
  begin : g_chk
    $error("HRST_CYC out of range");
  end

  localparam logic [21:0] HCNT_MAX = 22'(HRST_CYC - 1);

  // sync vector bit positions
  localparam int SY_TXEN = 4;
  localparam int SY_TXCLK = 5;
  localparam int SY_RXCLK = 6;
  localparam int SY_HRST = 7;
  localparam int SY_MODEA = 8;
  localparam int SY_MODEB = 9;
  localparam int SY_WOL = 10;
  localparam int SY_ADR0 = 11;
  localparam int SY_ADR1 = 12;

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [1:0] s3;
    logic [21:0] hcnt;
    logic pend;
    logic [1:0] strap_mode;
    logic strap_wol;
    logic [1:0] strap_addr;
    logic [15:0] ctl;
    logic [1:0] mode;
    logic xtal;
    logic rloop;
    logic col_seen;
    logic link_ll;
    logic [5:0] div;
    logic clk_o;
    logic txh;
    logic [1:0] txlo;
    logic tx_act;
    logic [3:0] rxbuf;
    logic rxfull;
    logic rxh;
    logic [3:0] rxd;
    logic rx_dv;
    logic crs;
    logic col;
    logic [3:0] ltx_d;
    logic ltx_stb;
    logic an_rst;
    logic led0;
    logic led1;
    logic oe_rx;
    logic oe_rxclk;
    logic oe_txclk;
    logic oe_led;
    logic pll_pin;
    logic wr;
    logic [31:0] rdata;
  } pmi_st_t;

  pmi_st_t q;
  pmi_st_t n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pmi_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic hard, iso, fast, gen, rmii, loop, tfall, rfall, gfall, tx_ev, rx_ev;
  logic ten, nv, src_v, src_act, take, swrst;
  logic [3:0] nd, src_d;
  logic [5:0] half;
  logic [15:0] w;
  logic [31:0] rv;

  always_comb
  begin
    n = q;
    n.s1 = {led1_i, led0_i, mii_rxd_i[1], mii_rxd_i[3], mii_rx_dv_i, hard_reset_n_pin,
            mii_rx_clk_i, mii_tx_clk_i, mii_tx_en_i, mii_txd_i};
    n.s2 = q.s1;
    n.s3 = q.s2[SY_RXCLK:SY_TXCLK];
    n.an_rst = 1'b0;
    n.ltx_stb = 1'b0;

    // pin must stay low the full minimum time; shorter dips are glitches
    if (q.s2[SY_HRST])
    begin
      n.hcnt = '0;
    end
    else if (q.hcnt != HCNT_MAX)
    begin
      n.hcnt = q.hcnt + 22'h1;
    end
    hard = !q.s2[SY_HRST] && (q.hcnt == HCNT_MAX); // [RULE_17]

    // straps sampled once the pin (and system reset) let go
    if (q.pend && q.s2[SY_HRST])
    begin
      n.strap_mode = {q.s2[SY_MODEA], q.s2[SY_MODEB]}; // [RULE_13] [RULE_14]
      n.strap_wol = q.s2[SY_WOL]; // [RULE_15]
      n.strap_addr = {q.s2[SY_ADR1], q.s2[SY_ADR0]}; // [RULE_16]
      n.mode = {q.s2[SY_MODEA], q.s2[SY_MODEB]}; // [RULE_22]
      n.pend = 1'b0;
    end

    iso = q.ctl[CTL_ISO] | q.pend;
    fast = q.ctl[CTL_SPD0] & !q.ctl[CTL_SPD1];
    gen = (q.mode == pmi_mii_mode) || (q.mode == reduced_if_clock_out_mode);
    rmii = q.mode[1];
    loop = q.ctl[CTL_ILOOP] | q.rloop;

    // ---------------- clocks ----------------
    half = (q.mode == reduced_if_clock_out_mode) ? RMII_HALF_CYC :
           (fast ? MII100_HALF_CYC : MII10_HALF_CYC); // [RULE_08]
    gfall = 1'b0;
    if (gen)
    begin
      if (q.div >= half - 6'h1)
      begin
        n.div = '0;
        n.clk_o = !q.clk_o;
        gfall = q.clk_o; // [RULE_05]
      end
      else
      begin
        n.div = q.div + 6'h1;
      end
    end
    else
    begin
      n.div = '0;
      n.clk_o = 1'b0;
    end
    tfall = q.s3[0] & !q.s2[SY_TXCLK];
    rfall = q.s3[1] & !q.s2[SY_RXCLK];
    // sample on the falling edge, half a period away from the mac's launch edge
    tx_ev = gen ? gfall : tfall;
    rx_ev = (q.mode == pmi_rev_mii_mode) ? rfall : tx_ev; // [RULE_09]
    n.pll_pin = (q.mode == reduced_if_clock_in_mode) & q.xtal; // [RULE_07]

    // ---------------- transmit ----------------
    ten = q.s2[SY_TXEN] & !iso; // [RULE_23]
    nv = 1'b0;
    nd = q.s2[3:0];
    if (tx_ev)
    begin
      n.tx_act = ten; // [RULE_04]
      if (rmii)
      begin
        // dibits pair low first; a lone dibit at frame end is dropped
        if (!ten)
        begin
          n.txh = 1'b0;
        end
        else if (!q.txh)
        begin
          n.txlo = q.s2[1:0];
          n.txh = 1'b1;
        end
        else
        begin
          nv = 1'b1;
          nd = {q.s2[1:0], q.txlo};
          n.txh = 1'b0;
        end
      end
      else
      begin
        nv = ten; // [RULE_01]
      end
    end
    if (nv && !q.ctl[CTL_ILOOP])
    begin
      n.ltx_stb = 1'b1; // [RULE_11]
      n.ltx_d = nd;
    end

    // ---------------- receive ----------------
    src_v = loop ? nv : line_rx_stb; // [RULE_10] [RULE_12] [RULE_24]
    src_d = loop ? nd : line_rx_d;
    src_act = loop ? q.tx_act : line_rx_dv;
    if (rx_ev)
    begin
      if (!rmii)
      begin
        n.rxd = q.rxbuf; // [RULE_06]
        n.rx_dv = q.rxfull;
        n.rxfull = 1'b0;
      end
      else if (q.rxh)
      begin
        n.rxd = {2'b00, q.rxbuf[3:2]};
        n.rxh = 1'b0;
        n.rxfull = 1'b0;
      end
      else if (q.rxfull)
      begin
        n.rxd = {2'b00, q.rxbuf[1:0]};
        n.rx_dv = 1'b1;
        n.rxh = 1'b1;
      end
      else
      begin
        n.rx_dv = 1'b0;
      end
    end
    if (src_v)
    begin
      n.rxbuf = src_d;
      n.rxfull = 1'b1;
    end
    n.crs = q.tx_act | src_act; // [RULE_02]
    n.col = q.tx_act & ((!q.ctl[CTL_DUP] & line_rx_dv & !loop) | q.ctl[CTL_COLT]); // [RULE_03]

    // ---------------- pins ----------------
    n.led0 = q.strap_wol ? !wol_req : link_up; // [RULE_15]
    n.led1 = q.crs;
    n.oe_rx = !iso; // [RULE_23]
    n.oe_rxclk = !iso && (q.mode == pmi_mii_mode); // [RULE_09]
    n.oe_txclk = !iso && gen; // [RULE_05] [RULE_08]
    n.oe_led = !q.pend;

    // ---------------- register bus ----------------
    rv = '0;
    unique case (avs_address)
      REG_CTRL: rv[15:0] = q.ctl;
      REG_STAT:
      begin
        rv[ST_COL] = q.col_seen;
        rv[ST_LINK] = q.link_ll;
        rv[ST_CRS] = q.crs;
        rv[ST_LINKNOW] = link_up;
      end
      REG_STRAP:
      begin
        rv[SP_MODE +: 2] = q.strap_mode;
        rv[SP_WOL] = q.strap_wol;
        rv[SP_ADDR +: 5] = {3'b000, q.strap_addr}; // [RULE_16]
      end
      REG_MODE:
      begin
        rv[MD_MODE +: 2] = q.mode;
        rv[MD_XTAL] = q.xtal;
        rv[MD_RLOOP] = q.rloop;
      end
      default: rv = '0;
    endcase
    take = !q.wr && (avs_read || avs_write);
    n.wr = 1'b1;
    if (q.wr && (avs_read || avs_write))
    begin
      n.wr = 1'b0;
      n.rdata = rv;
    end

    // sticky fields: a new event outranks the clear, and only reported values clear
    n.col_seen = q.col | (q.col_seen &
                 !(take && avs_read && avs_address == REG_STAT && q.rdata[ST_COL])); // [RULE_25] [RULE_21]
    n.link_ll = link_up & (q.link_ll |
                (take && avs_read && avs_address == REG_STAT && !q.rdata[ST_LINK])); // [RULE_25]

    swrst = 1'b0;
    w = pmi_merge(q.ctl, avs_writedata, avs_byteenable);
    if (take && avs_write && avs_address == REG_CTRL)
    begin
      if (w[CTL_SWRST])
      begin
        swrst = 1'b1; // [RULE_18] [RULE_20]
      end
      else
      begin
        n.ctl = w & CTL_WMASK; // [RULE_20]
        n.an_rst = w[CTL_ANRST];
      end
    end
    if (take && avs_write && avs_address == REG_MODE)
    begin
      w = pmi_merge({7'h00, q.rloop, 1'b0, q.xtal, 4'h0, q.mode}, avs_writedata,
                    avs_byteenable);
      n.mode = w[MD_MODE +: 2];
      n.xtal = w[MD_XTAL]; // [RULE_07]
      n.rloop = w[MD_RLOOP]; // [RULE_12]
    end
    if (swrst)
    begin
      n.ctl = CTL_RST; // [RULE_18]
      n.mode = q.strap_mode; // [RULE_22]
      n.xtal = 1'b0;
      n.rloop = 1'b0;
      n.col_seen = 1'b0; // [RULE_21]
      n.link_ll = 1'b1; // [RULE_21]
    end
    if (hard)
    begin
      n.ctl = CTL_RST; // [RULE_17]
      n.xtal = 1'b0;
      n.rloop = 1'b0;
      n.col_seen = 1'b0;
      n.link_ll = 1'b1;
      n.pend = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.pend <= 1'b1;
      q.wr <= 1'b1;
      q.ctl <= CTL_RST;
      q.link_ll <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wr;
  assign mii_tx_clk_o = q.clk_o;
  assign mii_tx_clk_oe = q.oe_txclk;
  assign mii_rx_clk_o = q.clk_o;
  assign mii_rx_clk_oe = q.oe_rxclk;
  assign mii_rxd_o = q.rxd;
  assign mii_rxd_oe = q.oe_rx;
  assign mii_rx_dv_o = q.rx_dv;
  assign mii_rx_dv_oe = q.oe_rx;
  assign mii_crs_o = q.crs;
  assign mii_col_o = q.col;
  assign led0_o = q.led0;
  assign led0_oe = q.oe_led;
  assign led1_o = q.led1;
  assign led1_oe = q.oe_led;
  assign line_tx_d = q.ltx_d;
  assign line_tx_stb = q.ltx_stb;
  assign an_restart_pulse = q.an_rst;
  assign an_enable = q.ctl[CTL_ANEN];
  assign power_down = q.ctl[CTL_PWD];
  assign pll_ref_from_pin = q.pll_pin;
  assign phy_addr = {3'b000, q.strap_addr};

endmodule
`default_nettype wire

// [hdl/pmi_pkg.sv]
// constants and types shared by the mac-side interface control block
package pmi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MII100_HALF_NS = 20;
  localparam int unsigned MII10_HALF_NS = 200;
  localparam int unsigned RMII_HALF_NS = 10;
  localparam logic [5:0] MII100_HALF_CYC = 6'(MII100_HALF_NS / CLK_PERIOD_NS);
  localparam logic [5:0] MII10_HALF_CYC = 6'(MII10_HALF_NS / CLK_PERIOD_NS);
  localparam logic [5:0] RMII_HALF_CYC = 6'(RMII_HALF_NS / CLK_PERIOD_NS);
  localparam int unsigned HARD_RST_MS = 10;
  localparam int unsigned HARD_RST_CYC = HARD_RST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SW_RST_WAIT_US = 100;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_STRAP = 4'h8;
  localparam logic [3:0] REG_MODE = 4'hc;

  // basic_control_reg fields
  localparam int CTL_SWRST = 15;
  localparam int CTL_ILOOP = 14;
  localparam int CTL_SPD0 = 13;
  localparam int CTL_ANEN = 12;
  localparam int CTL_PWD = 11;
  localparam int CTL_ISO = 10;
  localparam int CTL_ANRST = 9;
  localparam int CTL_DUP = 8;
  localparam int CTL_COLT = 7;
  localparam int CTL_SPD1 = 6;
  localparam logic [15:0] CTL_RST = 16'h3100;
  localparam logic [15:0] CTL_WMASK = 16'h7dc0;

  // status fields
  localparam int ST_COL = 0;
  localparam int ST_LINK = 1;
  localparam int ST_CRS = 2;
  localparam int ST_LINKNOW = 3;

  // strap register fields
  localparam int SP_MODE = 0;
  localparam int SP_WOL = 2;
  localparam int SP_ADDR = 3;

  // mode register fields
  localparam int MD_MODE = 0;
  localparam int MD_XTAL = 6;
  localparam int MD_RLOOP = 8;

  typedef enum logic [1:0] {
    pmi_mii_mode = 2'b00,
    pmi_rev_mii_mode = 2'b01,
    reduced_if_clock_out_mode = 2'b10,
    reduced_if_clock_in_mode = 2'b11
  } pmi_mode_t;

endpackage

// [dv/pmi_mac_sva.sv]
// assertions on the mac-facing, line-side and phy-control ports of the interface control block
`timescale 1ns/10ps
`default_nettype none
module pmi_mac_sva
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic line_rx_dv,
  input wire logic mii_crs_o,
  input wire logic mii_col_o,
  input wire logic [4:0] phy_addr,
  input wire logic line_tx_stb,
  input wire logic an_restart_pulse,
  input wire logic mii_tx_clk_o,
  input wire logic mii_tx_clk_oe,
  input wire logic mii_rx_clk_o,
  input wire logic mii_rx_clk_oe,
  input wire logic pll_ref_from_pin
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_crs_rx: assert property (
    line_rx_dv [*3] |-> mii_crs_o) else $error("carrier sense missing while receiving");
  a_col_crs: assert property (
    $rose(mii_col_o) |-> ##[0:1] mii_crs_o) else $error("collision without carrier");
  a_addr_upper: assert property (
    phy_addr[4:2] == 3'h0) else $error("management address upper bits set");
  a_stb_single: assert property (
    line_tx_stb |=> !line_tx_stb) else $error("transmit strobe longer than one cycle");
  a_restart_pulse: assert property (
    an_restart_pulse |=> !an_restart_pulse) else $error("restart field did not self clear");
  // fastest half period is 2 cycles, slowest 40; frozen clock while floated is allowed
  a_clk_fall: assert property (@(posedge clk_sys) disable iff (!resetn || !mii_tx_clk_oe)
    $rose(mii_tx_clk_o) |-> ##[2:40] $fell(mii_tx_clk_o)) else $error("transmit clock stuck");
  a_rxclk_wave: assert property (
    mii_rx_clk_oe |-> mii_tx_clk_oe && mii_rx_clk_o == mii_tx_clk_o) else $error("rx clock wave");
  a_pll_input: assert property (
    pll_ref_from_pin |-> !mii_tx_clk_oe) else $error("reference pin driven in clock-in mode");
endmodule
bind pmi_mac_side_if pmi_mac_sva pmi_mac_sva_i (.*);
`default_nettype wire

// [dv/pmi_mac_model.sv]
// mac partner: presents transmit nibbles after rising edges of the transmit clock
`timescale 1ns/10ps
`default_nettype none
module pmi_mac_model
(
  input wire logic clk_sys,
  input wire logic tx_clk,
  input wire logic go,
  input wire logic [3:0] nib,
  output logic tx_en,
  output logic [3:0] txd,
  output logic took
);
  logic clk_q = 1'b0;
  initial
  begin
    tx_en = 1'b0;
    txd = 4'h0;
    took = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    clk_q <= tx_clk;
    took <= 1'b0;
    if (tx_clk && !clk_q)
    begin
      tx_en <= go;
      // idle lines toggle so a stale nibble is never mistaken for data
      txd <= go ? nib : ~txd;
      took <= go;
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the mac-side interface control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmi_pkg::*;
  logic clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0, hard_reset_n_pin = 1;
  logic [3:0] avs_address = 0, avs_byteenable = 4'h3, line_rx_d = 0, mii_txd_i, mii_rxd_i;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic line_rx_stb = 0, line_rx_dv = 0, link_up = 1, wol_req = 0, lk = 0, lk_en = 0, ext = 0;
  logic avs_waitrequest, mii_tx_en_i, mii_tx_clk_i, mii_tx_clk_o, mii_tx_clk_oe, mii_rx_clk_i;
  logic mii_rx_clk_o, mii_rx_clk_oe, mii_rxd_oe, mii_rx_dv_i, mii_rx_dv_o, mii_rx_dv_oe;
  logic mii_crs_o, mii_col_o, led0_i, led0_o, led0_oe, led1_i, led1_o, led1_oe, line_tx_stb;
  logic an_restart_pulse, an_enable, power_down, pll_ref_from_pin, took, tck_q = 0;
  logic col_s = 0, crs_s = 0;
  logic [3:0] mii_rxd_o, line_tx_d;
  logic [4:0] phy_addr;
  logic [1:0] st_mode = 0, st_addr = 0;
  logic st_wol = 0;
  int num_errors = 0, compares = 0, tx_n = 0, ln_n = 0, rx_n = 0, an_n = 0, want = 0;
  int per = 0, last_per = 0;

  // each shared pin resolves to whoever enables it, else the strap or link clock
  assign mii_rxd_i = mii_rxd_oe ? mii_rxd_o : {st_mode[0], 1'b0, st_wol, 1'b0};
  assign mii_rx_dv_i = mii_rx_dv_oe ? mii_rx_dv_o : st_mode[1];
  assign led0_i = led0_oe ? led0_o : st_addr[0];
  assign led1_i = led1_oe ? led1_o : st_addr[1];
  assign mii_tx_clk_i = mii_tx_clk_oe ? mii_tx_clk_o : lk;
  assign mii_rx_clk_i = mii_rx_clk_oe ? mii_rx_clk_o : lk;

  pmi_mac_side_if #(.HRST_CYC(8)) pmi_mac_side_if_i (.*);
  pmi_mac_model pmi_mac_model_i (.clk_sys(clk_sys), .tx_clk(mii_tx_clk_i), .go(tx_n < want),
    .nib(4'(tx_n) ^ 4'ha), .tx_en(mii_tx_en_i), .txd(mii_txd_i), .took(took));

  always #2.5 clk_sys = ~clk_sys;
  always #32 if (lk_en) lk = ~lk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    tck_q <= mii_tx_clk_o;
    per <= per + 1;
    col_s <= col_s | mii_col_o;
    crs_s <= crs_s | mii_crs_o;
    an_n <= an_n + int'(an_restart_pulse);
    if (took)
      tx_n <= tx_n + 1;
    if (ext)
    begin
      // loopback stub: the line answers one cycle later with what it was sent
      line_rx_d <= line_tx_d;
      line_rx_stb <= line_tx_stb;
      line_rx_dv <= mii_tx_en_i;
    end
    if (line_tx_stb)
    begin
      check(32'(line_tx_d), 32'(4'(ln_n) ^ 4'ha));
      ln_n <= ln_n + 1;
    end
    if (mii_tx_clk_o && !tck_q)
    begin
      last_per <= per + 1;
      per <= 0;
      if (mii_rx_dv_o)
      begin
        check(32'(mii_rxd_o), 32'(4'(rx_n) ^ 4'ha));
        rx_n <= rx_n + 1;
      end
    end
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // no assumed latency: only the watchdog ends a wait that never answers
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic clr;
    tx_n <= 0;
    ln_n <= 0;
    rx_n <= 0;
    col_s <= 0;
    crs_s <= 0;
    @(posedge clk_sys);
  endtask

  task automatic frame(input int n, input int e_line, input int e_rx);
    int k;
    clr();
    want <= n;
    lk_en = 1;
    for (k = 0; k < 3000 && tx_n < n; k++)
      @(posedge clk_sys);
    repeat (60) @(posedge clk_sys);
    want <= 0;
    lk_en = 0;
    check(32'(ln_n), 32'(e_line));
    check(32'(rx_n), 32'(e_rx));
  endtask

  task automatic rxf(input int n);
    int i;
    clr();
    line_rx_dv <= 1'b1;
    for (i = 0; i < n; i++)
    begin
      line_rx_d <= 4'(i) ^ 4'ha;
      line_rx_stb <= 1'b1;
      @(posedge clk_sys);
      line_rx_stb <= 1'b0;
      repeat (7) @(posedge clk_sys);
    end
    line_rx_dv <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask

  task automatic hr(input logic [1:0] m, input logic w, input logic [1:0] a);
    st_mode <= m;
    st_wol <= w;
    st_addr <= a;
    hard_reset_n_pin <= 1'b0;
    repeat (12) @(posedge clk_sys);
    hard_reset_n_pin <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask

  initial
  begin
    #300us;
    num_errors++;
    finish_test();
  end

  initial
  begin
    st_wol = 1'b1;
    st_addr = 2'b10;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check(32'(phy_addr), 32'({3'h0, st_addr}));
    rd(REG_STRAP, 32'hff, 32'({3'h0, st_addr, st_wol, st_mode}));
    rd(REG_CTRL, 32'hffff, 32'(CTL_RST));
    rd(REG_MODE, 32'h3, 32'(st_mode));
    rd(4'h2, 32'hffffffff, 32'h0);
    wol_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(32'(led0_o), 32'h0);
    check(32'(last_per), 32'(2 * MII100_HALF_CYC));
    link_up <= 1'b0;
    repeat (4) @(posedge clk_sys);
    link_up <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(REG_STAT, 32'ha, 32'h8);
    rd(REG_STAT, 32'ha, 32'ha);
    rxf(5);
    check(32'(rx_n), 32'h5);
    check(32'(crs_s), 32'h1);
    frame(6, 6, 0);
    check(32'(crs_s), 32'h1);
    ext = 1'b1;
    frame(6, 6, 6);
    wr(REG_CTRL, 32'h3000);
    frame(6, 6, 6);
    ext = 1'b0;
    check(32'(col_s), 32'h1);
    wr(REG_MODE, 32'h101);
    wr(REG_CTRL, 32'h8000);
    // host quiet time after a soft reset before any further register access
    repeat (SW_RST_WAIT_US * 1000 / CLK_PERIOD_NS) @(posedge clk_sys);
    rd(REG_CTRL, 32'hffff, 32'(CTL_RST));
    rd(REG_MODE, 32'h1ff, 32'(st_mode));
    rd(REG_STAT, 32'h3, 32'h2);
    rd(REG_STRAP, 32'hff, 32'({3'h0, st_addr, st_wol, st_mode}));
    wr(REG_MODE, 32'h100);
    frame(6, 6, 6);
    wr(REG_MODE, 32'h0);
    wr(REG_CTRL, 32'h7100);
    frame(6, 0, 6);
    wr(REG_CTRL, 32'h3500);
    // enable follows the control bit one edge after the write lands
    @(posedge clk_sys);
    check(32'(mii_rxd_oe), 32'h0);
    frame(6, 0, 0);
    wr(REG_CTRL, 32'h3300);
    // pulse is counted one edge after it appears
    @(posedge clk_sys);
    check(32'(an_n), 32'h1);
    rd(REG_CTRL, 32'h8200, 32'h0);
    hr(2'b10, 1'b0, 2'b01);
    check(32'(phy_addr), 32'h1);
    rd(REG_STRAP, 32'hff, 32'({3'h0, st_addr, st_wol, st_mode}));
    rd(REG_CTRL, 32'hffff, 32'(CTL_RST));
    repeat (20) @(posedge clk_sys);
    check(32'(last_per), 32'(2 * RMII_HALF_CYC));
    check(32'(mii_rx_clk_oe), 32'h0);
    hr(2'b11, 1'b0, 2'b00);
    wr(REG_MODE, 32'h43);
    repeat (3) @(posedge clk_sys);
    check(32'(pll_ref_from_pin), 32'h1);
    check(32'(mii_tx_clk_oe), 32'h0);
    hr(2'b01, 1'b0, 2'b00);
    check(32'(mii_tx_clk_oe), 32'h0);
    frame(6, 6, 0);
    finish_test();
  end
endmodule
`default_nettype wire
